// *** axb_chk_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module axb_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_external_fetch_select,
  input wire logic o_ale,
  input wire logic o_program_fetch_strobe_n,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_low_addr_data_port_oe_n,
  input wire logic [7:0] o_high_addr_port_out,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic o_sfr_hit,
  input wire logic i_iram_req,
  input wire logic i_iram_indirect,
  input wire logic [7:0] i_iram_addr,
  input wire logic o_iram_ack,
  input wire logic o_iram_err,
  input wire logic i_xmov_req,
  input wire logic o_xmov_ack,
  input wire logic o_xmov_on_chip
);
  // One clock domain, so one clocking and one reset for all checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_ale_cadence: assert property ($rose(o_ale) |=> o_ale ##1 !o_ale [*4] ##1 o_ale)
    else $error("address latch strobe cadence wrong");
  // Sixteen cycles cover the select sync plus a slot already under way
  a_int_no_fetch: assert property (i_external_fetch_select [*8] ##1 i_external_fetch_select [*8] |-> o_program_fetch_strobe_n)
    else $error("fetch strobe while internal code selected");
  a_fetch_shape: assert property ($fell(o_program_fetch_strobe_n) |-> !o_ale ##1 !o_program_fetch_strobe_n [*2] ##1 o_program_fetch_strobe_n)
    else $error("fetch strobe shape wrong");
  a_rd_phase: assert property ($fell(o_rd_n) |-> !o_ale && o_low_addr_data_port_oe_n && !$past(o_low_addr_data_port_oe_n, 3) ##1 !o_rd_n [*2] ##1 o_rd_n)
    else $error("read strobe or port release wrong");
  a_wr_drive: assert property ($fell(o_wr_n) |-> (!o_wr_n && !o_low_addr_data_port_oe_n) [*3] ##1 o_wr_n)
    else $error("write data not driven under strobe");
  a_high_hold: assert property (!o_rd_n || !o_wr_n |-> $stable(o_high_addr_port_out))
    else $error("high address moved under strobe");
  a_sfr_decode: assert property (i_sfr_wr || i_sfr_rd |=> o_sfr_hit == ($past(i_sfr_addr) == 8'hbf || $past(i_sfr_addr) == 8'hf6))
    else $error("register hit decode wrong");
  a_iram_split: assert property (i_iram_req && !o_iram_ack |=> o_iram_ack && o_iram_err == (!$past(i_iram_indirect) && $past(i_iram_addr) >= 8'h80))
    else $error("scratchpad answer or error wrong");
  a_aux_quiet: assert property (o_xmov_ack && o_xmov_on_chip |-> $past(i_xmov_req) && o_rd_n && o_wr_n && $past(o_rd_n) && $past(o_wr_n))
    else $error("auxiliary access touched the bus");
  a_bus_ack: assert property (o_xmov_ack && !o_xmov_on_chip |-> o_ale && !($past(o_rd_n) && $past(o_wr_n)))
    else $error("bus move acknowledged without a strobe");
endmodule // axb_chk
`default_nettype wire

// *** axb_map.vh ***
`ifndef AXB_MAP_VH
`define AXB_MAP_VH

// Special function register addresses served by this block
`define AXB_CFG_ADDR 8'hbf
`define AXB_UNLOCK_ADDR 8'hf6

// Unlock sequence values
`define AXB_UNLOCK_KEY1 8'h87
`define AXB_UNLOCK_KEY2 8'h59
`define AXB_UNLOCK_RELOCK 8'h00

// Unlock progress codes
`define AXB_LOCK_CLOSED 2'h0
`define AXB_LOCK_HALF 2'h1
`define AXB_LOCK_OPEN 2'h2

// Chip configuration: auxiliary RAM enable bit, stored bits, reset values
`define AXB_CFG_AUXEN_BIT 4
`define AXB_CFG_MASK 8'h9f
`define AXB_CFG_RST 8'h00
`define AXB_UNLOCK_RST 8'h00

// Scratchpad: bit that marks the indirect-only upper half
`define AXB_SP_UPPER_BIT 7

// Bus slot: three internal states of two oscillator cycles each
`define AXB_ST_ALE 2'h0
`define AXB_ST_HOLD 2'h1
`define AXB_ST_LAST 2'h2

// Bus cycle kinds
`define AXB_KIND_FETCH 2'h0
`define AXB_KIND_XRD 2'h1
`define AXB_KIND_XWR 2'h2

// Idle level of the released low address/data port
`define AXB_P0_IDLE 8'hff

`endif

// *** axb_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
module axb_mem (
  input wire logic i_clk,
  input wire logic i_ale,
  input wire logic i_program_fetch_strobe_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_p0_out,
  input wire logic i_p0_oe_n,
  input wire logic [7:0] i_p2_out,
  output logic [7:0] o_p0_wire
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_q;
  logic [7:0] last_q = 8'h00;
  logic [7:0] dval;
  logic drv;
  wire [15:0] addr = {i_p2_out, lo_q};

  // Latch loads at each falling clock edge while the strobe is high, holds when it drops
  always @(negedge i_clk) begin
    if (i_ale) lo_q <= o_p0_wire;
    if (!i_wr_n) mem[addr] <= o_p0_wire;
    if (drv) last_q <= dval;
  end

  // Code bytes are a pattern of the address; released wire shows no stale value
  always @* begin
    drv = !i_p0_oe_n || !i_program_fetch_strobe_n || !i_rd_n;
    if (!i_p0_oe_n) dval = i_p0_out;
    else if (!i_program_fetch_strobe_n) dval = addr[7:0] ^ addr[15:8] ^ 8'h5a;
    else dval = mem[addr];
    o_p0_wire = drv ? dval : ~last_q;
  end
endmodule // axb_mem
`default_nettype wire

// *** axb_ram.v ***
`timescale 1ns/10ps
`default_nettype none

// Flip-flop storage, one write port and two combinational read ports
module axb_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire i_clk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr_a,
  output wire [DW-1:0] o_rdata_a,
  input wire [AW-1:0] i_raddr_b,
  output wire [DW-1:0] o_rdata_b
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // Contents are not reset; software owns the initial values
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Reads see the array directly so the pointer and data can chain in one cycle
  assign o_rdata_a = mem_r[i_raddr_a];
  assign o_rdata_b = mem_r[i_raddr_b];

endmodule // axb_ram

`default_nettype wire

// *** axb_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "axb_map.vh"

module axb_top (
  input wire i_clk,
  input wire i_arst_n,
  // Pins
  input wire i_external_fetch_select,
  output reg o_ale,
  output reg o_program_fetch_strobe_n,
  output reg o_rd_n,
  output reg o_wr_n,
  input wire [7:0] i_low_addr_data_port_in,
  output reg [7:0] o_low_addr_data_port_out,
  output reg o_low_addr_data_port_oe_n,
  output reg [7:0] o_high_addr_port_out,
  output reg o_high_addr_port_oe_n,
  // Core side: port latch of the high address port
  input wire [7:0] i_p2_sfr,
  // Core side: register bank and index pointer choice
  input wire [1:0] i_bank_sel,
  input wire i_ptr_sel,
  // Core side: code fetch
  input wire i_fetch_req,
  input wire [15:0] i_fetch_addr,
  input wire [7:0] i_irom_rdata,
  output reg o_fetch_ack,
  output reg [7:0] o_fetch_rdata,
  // Core side: external data move
  input wire i_xmov_req,
  input wire i_xmov_wr,
  input wire i_xmov_use_data_pointer_pair,
  input wire [15:0] i_data_pointer_pair,
  input wire [7:0] i_xmov_wdata,
  output reg o_xmov_ack,
  output reg [7:0] o_xmov_rdata,
  output reg o_xmov_on_chip,
  // Core side: scratchpad access
  input wire i_iram_req,
  input wire i_iram_wr,
  input wire i_iram_indirect,
  input wire [7:0] i_iram_addr,
  input wire [7:0] i_iram_wdata,
  output reg o_iram_ack,
  output reg o_iram_err,
  output reg [7:0] o_iram_rdata,
  // Core side: special function register access
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  output reg o_sfr_hit,
  output reg [7:0] o_sfr_rdata
);

  // Synchronisers for pins
  reg ea_meta_r;
  reg ea_sync_r;
  reg [7:0] p0_meta_r;
  reg [7:0] p0_sync_r;

  // Slot timing: ph_r halves the oscillator, st_r counts internal states
  reg ph_r;
  reg [1:0] st_r;
  reg ph_nxt;
  reg [1:0] st_nxt;
  wire slot_end;

  // Bus cycle state
  reg busy_r;
  reg [1:0] kind_r;
  reg [15:0] addr_r;
  reg [7:0] wdata_r;
  reg busy_nxt;
  reg [1:0] kind_nxt;
  reg [15:0] addr_nxt;
  reg [7:0] wdata_nxt;

  // Configuration and unlock
  reg [7:0] cfg_r;
  reg [7:0] unlock_r;
  reg [1:0] lock_r;
  wire aux_en;

  // Memory wiring
  wire [7:0] ptr_loc;
  wire [7:0] ptr_val;
  wire [7:0] sp_addr;
  wire [7:0] sp_rdata;
  wire sp_we;
  wire [7:0] aux_addr;
  wire [7:0] aux_rdata;
  wire aux_we;

  // Request decode
  wire fetch_ext;
  wire fetch_int_go;
  wire xmov_aux;
  wire xmov_aux_go;
  wire xmov_ext_pend;
  wire fetch_ext_pend;
  wire iram_go;
  wire iram_bad;

  // Pin next values
  reg addr_phase;
  reg ale_nxt;
  reg program_fetch_strobe_n_nxt;
  reg rd_n_nxt;
  reg wr_n_nxt;
  reg [7:0] p0_out_nxt;
  reg p0_oe_n_nxt;
  reg [7:0] p2_out_nxt;

  // Two flops before any logic looks at a pin; select reset as internal fetch
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ea_meta_r <= 1'b1;
      ea_sync_r <= 1'b1;
      p0_meta_r <= `AXB_P0_IDLE;
      p0_sync_r <= `AXB_P0_IDLE;
    end else begin
      ea_meta_r <= i_external_fetch_select;
      ea_sync_r <= ea_meta_r;
      p0_meta_r <= i_low_addr_data_port_in;
      p0_sync_r <= p0_meta_r;
    end
  end

  // Divide by two, then three internal states per slot
  always @* begin
    ph_nxt = ~ph_r;
    st_nxt = st_r;
    if (ph_r) begin
      if (st_r == `AXB_ST_LAST) begin
        st_nxt = `AXB_ST_ALE;
      end else begin
        st_nxt = st_r + 2'h1;
      end
    end
  end

  assign slot_end = ph_r && (st_r == `AXB_ST_LAST);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ph_r <= 1'b1; // Park at slot end so the first strobe after release is full width
      st_r <= `AXB_ST_LAST;
    end else begin
      ph_r <= ph_nxt;
      st_r <= st_nxt;
    end
  end

  // Unlock progress: any value off the sequence closes it again
  assign aux_en = cfg_r[`AXB_CFG_AUXEN_BIT];

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= `AXB_CFG_RST;
      unlock_r <= `AXB_UNLOCK_RST;
      lock_r <= `AXB_LOCK_CLOSED;
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == `AXB_UNLOCK_ADDR) begin
        unlock_r <= i_sfr_wdata;
        if (i_sfr_wdata == `AXB_UNLOCK_KEY1) begin
          lock_r <= `AXB_LOCK_HALF;
        end else if (i_sfr_wdata == `AXB_UNLOCK_KEY2 && lock_r == `AXB_LOCK_HALF) begin
          lock_r <= `AXB_LOCK_OPEN;
        end else begin
          lock_r <= `AXB_LOCK_CLOSED; // relock value lands here too
        end
      end else if (i_sfr_addr == `AXB_CFG_ADDR && lock_r == `AXB_LOCK_OPEN) begin
        cfg_r <= i_sfr_wdata & `AXB_CFG_MASK;
      end
    end
  end

  // Register reads answer one cycle later; other addresses give no hit
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sfr_hit <= 1'b0;
      o_sfr_rdata <= 8'h00;
    end else begin
      o_sfr_hit <= (i_sfr_rd || i_sfr_wr) &&
                   (i_sfr_addr == `AXB_CFG_ADDR || i_sfr_addr == `AXB_UNLOCK_ADDR);
      if (i_sfr_rd && i_sfr_addr == `AXB_CFG_ADDR) begin
        o_sfr_rdata <= cfg_r;
      end else if (i_sfr_rd && i_sfr_addr == `AXB_UNLOCK_ADDR) begin
        o_sfr_rdata <= unlock_r;
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

  // Pointer of the selected bank lives in the low scratchpad
  assign ptr_loc = {5'h00, i_bank_sel, i_ptr_sel};
  assign iram_bad = !i_iram_indirect && i_iram_addr[`AXB_SP_UPPER_BIT];
  assign sp_addr = i_iram_indirect ? ptr_val : i_iram_addr;
  assign iram_go = i_iram_req && !o_iram_ack;
  assign sp_we = iram_go && i_iram_wr && !iram_bad;

  axb_ram #(
    .AW(8),
    .DW(8)
  ) u_scratch (
    .i_clk(i_clk),
    .i_we(sp_we),
    .i_waddr(sp_addr),
    .i_wdata(i_iram_wdata),
    .i_raddr_a(ptr_loc),
    .o_rdata_a(ptr_val),
    .i_raddr_b(sp_addr),
    .o_rdata_b(sp_rdata)
  );

  // Scratchpad answers the cycle after the request
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_iram_ack <= 1'b0;
      o_iram_err <= 1'b0;
      o_iram_rdata <= 8'h00;
    end else begin
      o_iram_ack <= iram_go;
      o_iram_err <= iram_go && iram_bad;
      if (iram_go && !i_iram_wr && !iram_bad) begin
        o_iram_rdata <= sp_rdata;
      end
    end
  end

  // Pointer moves always stay on chip when enabled; data pointer only up to FFH
  assign xmov_aux = aux_en &&
                    (!i_xmov_use_data_pointer_pair || i_data_pointer_pair[15:8] == 8'h00);
  assign aux_addr = i_xmov_use_data_pointer_pair ? i_data_pointer_pair[7:0] : ptr_val;
  assign xmov_aux_go = i_xmov_req && xmov_aux && !o_xmov_ack;
  assign aux_we = xmov_aux_go && i_xmov_wr;

  axb_ram #(
    .AW(8),
    .DW(8)
  ) u_aux (
    .i_clk(i_clk),
    .i_we(aux_we),
    .i_waddr(aux_addr),
    .i_wdata(i_xmov_wdata),
    .i_raddr_a(aux_addr),
    .o_rdata_a(aux_rdata),
    .i_raddr_b(aux_addr),
    .o_rdata_b()
  );

  // Fetch route follows the synchronised select pin
  assign fetch_ext = !ea_sync_r;
  assign fetch_int_go = i_fetch_req && !fetch_ext && !o_fetch_ack;
  assign xmov_ext_pend = i_xmov_req && !xmov_aux && !o_xmov_ack;
  assign fetch_ext_pend = i_fetch_req && fetch_ext && !o_fetch_ack;

  // Bus cycles start only at a slot boundary; a finished slot leaves one idle slot
  always @* begin
    busy_nxt = busy_r;
    kind_nxt = kind_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    if (slot_end) begin
      if (busy_r) begin
        busy_nxt = 1'b0;
      end else if (xmov_ext_pend) begin
        busy_nxt = 1'b1;
        kind_nxt = i_xmov_wr ? `AXB_KIND_XWR : `AXB_KIND_XRD;
        addr_nxt = i_xmov_use_data_pointer_pair ? i_data_pointer_pair : {i_p2_sfr, ptr_val};
        wdata_nxt = i_xmov_wdata;
      end else if (fetch_ext_pend) begin
        busy_nxt = 1'b1;
        kind_nxt = `AXB_KIND_FETCH;
        addr_nxt = i_fetch_addr;
        wdata_nxt = wdata_r;
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_r <= 1'b0;
      kind_r <= `AXB_KIND_FETCH;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
    end else begin
      busy_r <= busy_nxt;
      kind_r <= kind_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // Answers: internal fetch and auxiliary moves next cycle, bus ones at slot end
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fetch_ack <= 1'b0;
      o_fetch_rdata <= 8'h00;
      o_xmov_ack <= 1'b0;
      o_xmov_rdata <= 8'h00;
      o_xmov_on_chip <= 1'b0;
    end else begin
      o_fetch_ack <= 1'b0;
      o_xmov_ack <= 1'b0;
      if (fetch_int_go) begin
        o_fetch_ack <= 1'b1;
        o_fetch_rdata <= i_irom_rdata;
      end else if (slot_end && busy_r && kind_r == `AXB_KIND_FETCH) begin
        o_fetch_ack <= 1'b1;
        o_fetch_rdata <= p0_sync_r;
      end
      if (xmov_aux_go) begin
        o_xmov_ack <= 1'b1;
        o_xmov_on_chip <= 1'b1;
        if (!i_xmov_wr) begin
          o_xmov_rdata <= aux_rdata;
        end
      end else if (slot_end && busy_r && kind_r != `AXB_KIND_FETCH) begin
        o_xmov_ack <= 1'b1;
        o_xmov_on_chip <= 1'b0;
        if (kind_r == `AXB_KIND_XRD) begin
          o_xmov_rdata <= p0_sync_r;
        end
      end
    end
  end

  // Pin values for the coming cycle; auxiliary traffic never reaches here
  always @* begin
    addr_phase = (st_nxt == `AXB_ST_ALE) || (st_nxt == `AXB_ST_HOLD && !ph_nxt);
    ale_nxt = (st_nxt == `AXB_ST_ALE);
    program_fetch_strobe_n_nxt = !(busy_nxt && !addr_phase && kind_nxt == `AXB_KIND_FETCH);
    rd_n_nxt = !(busy_nxt && !addr_phase && kind_nxt == `AXB_KIND_XRD);
    wr_n_nxt = !(busy_nxt && !addr_phase && kind_nxt == `AXB_KIND_XWR);
    p0_out_nxt = `AXB_P0_IDLE;
    p0_oe_n_nxt = 1'b1;
    p2_out_nxt = i_p2_sfr;
    if (busy_nxt) begin
      p2_out_nxt = addr_nxt[15:8];
      if (addr_phase) begin
        p0_out_nxt = addr_nxt[7:0];
        p0_oe_n_nxt = 1'b0;
      end else if (kind_nxt == `AXB_KIND_XWR) begin
        p0_out_nxt = wdata_nxt;
        p0_oe_n_nxt = 1'b0;
      end
    end
  end

  // Every pin comes from a flop; reset leaves the bus released and strobes idle
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ale <= 1'b0;
      o_program_fetch_strobe_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_low_addr_data_port_out <= `AXB_P0_IDLE;
      o_low_addr_data_port_oe_n <= 1'b1;
      o_high_addr_port_out <= `AXB_P0_IDLE;
      o_high_addr_port_oe_n <= 1'b1;
    end else begin
      o_ale <= ale_nxt;
      o_program_fetch_strobe_n <= program_fetch_strobe_n_nxt;
      o_rd_n <= rd_n_nxt;
      o_wr_n <= wr_n_nxt;
      o_low_addr_data_port_out <= p0_out_nxt;
      o_low_addr_data_port_oe_n <= p0_oe_n_nxt;
      o_high_addr_port_out <= p2_out_nxt;
      o_high_addr_port_oe_n <= 1'b0;
    end
  end

endmodule // axb_top

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_arst_n = 0, i_external_fetch_select = 1;
  logic [7:0] i_p2_sfr = 8'h00, i_irom_rdata = 8'h00, i_xmov_wdata = 8'h00;
  logic [1:0] i_bank_sel = 2'h0;
  logic i_ptr_sel = 0, i_fetch_req = 0, i_xmov_req = 0, i_xmov_wr = 0, i_xmov_use_data_pointer_pair = 0;
  logic [15:0] i_fetch_addr = 16'h0000, i_data_pointer_pair = 16'h0000;
  logic i_iram_req = 0, i_iram_wr = 0, i_iram_indirect = 0, i_sfr_wr = 0, i_sfr_rd = 0;
  logic [7:0] i_iram_addr = 8'h00, i_iram_wdata = 8'h00, i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
  wire o_ale, o_program_fetch_strobe_n, o_rd_n, o_wr_n, o_low_addr_data_port_oe_n;
  wire o_high_addr_port_oe_n, o_fetch_ack, o_xmov_ack, o_xmov_on_chip, o_iram_ack;
  wire o_iram_err, o_sfr_hit;
  wire [7:0] i_low_addr_data_port_in, o_low_addr_data_port_out, o_high_addr_port_out;
  wire [7:0] o_fetch_rdata, o_xmov_rdata, o_iram_rdata, o_sfr_rdata;
  int err_total = 0;
  int total_checks = 0;
  logic [7:0] q;
  logic e;

  always #20 i_clk = ~i_clk;

  axb_top dut_u (.i_clk, .i_arst_n, .i_external_fetch_select, .o_ale,
    .o_program_fetch_strobe_n, .o_rd_n, .o_wr_n, .i_low_addr_data_port_in,
    .o_low_addr_data_port_out, .o_low_addr_data_port_oe_n, .o_high_addr_port_out,
    .o_high_addr_port_oe_n, .i_p2_sfr, .i_bank_sel, .i_ptr_sel, .i_fetch_req, .i_fetch_addr,
    .i_irom_rdata, .o_fetch_ack, .o_fetch_rdata, .i_xmov_req, .i_xmov_wr, .i_xmov_use_data_pointer_pair,
    .i_data_pointer_pair, .i_xmov_wdata, .o_xmov_ack, .o_xmov_rdata, .o_xmov_on_chip,
    .i_iram_req, .i_iram_wr, .i_iram_indirect, .i_iram_addr, .i_iram_wdata, .o_iram_ack,
    .o_iram_err, .o_iram_rdata, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_hit,
    .o_sfr_rdata);

  axb_mem mem_u (.i_clk(i_clk), .i_ale(o_ale), .i_program_fetch_strobe_n(o_program_fetch_strobe_n),
    .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_p0_out(o_low_addr_data_port_out),
    .i_p0_oe_n(o_low_addr_data_port_oe_n), .i_p2_out(o_high_addr_port_out),
    .o_p0_wire(i_low_addr_data_port_in));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    i_sfr_wr = 0;
  endtask

  task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    {i_sfr_rd, i_sfr_addr} = {1'b1, a};
    @(negedge i_clk);
    i_sfr_rd = 0;
    chk("sfr_rdata", exp, o_sfr_rdata);
  endtask

  // Scratchpad request held one cycle; answer is sampled with the ack
  task automatic iram(input logic w, ind, input logic [7:0] a, d);
    @(negedge i_clk);
    {i_iram_req, i_iram_wr, i_iram_indirect, i_iram_addr, i_iram_wdata} = {1'b1, w, ind, a, d};
    @(negedge i_clk);
    chk("iram_ack", 1, o_iram_ack);
    {q, e} = {o_iram_rdata, o_iram_err};
    i_iram_req = 0;
  endtask

  // Bus moves wait for a free slot, so the wait is bounded, not fixed
  task automatic xmov(input logic w, dp, input logic [15:0] a, input logic [7:0] d, input logic on);
    int n;
    @(negedge i_clk);
    {i_xmov_req, i_xmov_wr, i_xmov_use_data_pointer_pair, i_data_pointer_pair, i_xmov_wdata} = {1'b1, w, dp, a, d};
    n = 0;
    while (o_xmov_ack !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    chk("xmov_ack", 1, o_xmov_ack);
    chk("on_chip", on, o_xmov_on_chip);
    q = o_xmov_rdata;
    i_xmov_req = 0;
  endtask

  task automatic fetch(input logic [15:0] a, input logic [7:0] rom, exp);
    int n;
    @(negedge i_clk);
    {i_fetch_req, i_fetch_addr, i_irom_rdata} = {1'b1, a, rom};
    n = 0;
    while (o_fetch_ack !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    chk("fetch", exp, o_fetch_rdata);
    i_fetch_req = 0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge i_clk);
    i_arst_n = 1;
    sfr_r(8'hbf, 8'h00);
    sfr_r(8'hf6, 8'h00);
    chk("p2_oe_n", 0, o_high_addr_port_oe_n);
    // Pointer a of bank 0 aims at the upper half; a refused direct write must not land
    iram(1, 0, 8'h01, 8'h34);
    iram(1, 0, 8'h00, 8'h90);
    iram(1, 1, 8'h00, 8'h5c);
    iram(1, 0, 8'h90, 8'h11);
    chk("iram_err", 1, e);
    iram(0, 1, 8'h00, 8'h00);
    chk("iram_hi", 8'h5c, q);
    chk("iram_hi_err", 0, e);
    // Bank 1 pointer a sits at location 02 and points back at 01
    iram(1, 0, 8'h02, 8'h01);
    {i_bank_sel, i_ptr_sel} = {2'h1, 1'b0};
    iram(0, 1, 8'h00, 8'h00);
    chk("iram_bank", 8'h34, q);
    {i_bank_sel, i_ptr_sel} = {2'h0, 1'b1};
    iram(0, 0, 8'h01, 8'h00);
    chk("iram_ptr", 8'h34, q);
    // Auxiliary RAM off: a pointer move goes out on the bus
    xmov(1, 0, 16'h0000, 8'ha5, 0);
    chk("ext_mem", 8'ha5, mem_u.mem[16'h0034]);
    sfr_w(8'hbf, 8'h10);
    sfr_r(8'hbf, 8'h00);
    sfr_w(8'hf6, 8'h87);
    sfr_w(8'hf6, 8'h59);
    sfr_w(8'hbf, 8'h10);
    sfr_w(8'hf6, 8'h00);
    sfr_r(8'hbf, 8'h10);
    sfr_w(8'hbf, 8'h00);
    sfr_r(8'hbf, 8'h10);
    // Auxiliary RAM on: same address stays on chip, external copy untouched
    xmov(1, 0, 16'h0000, 8'h3c, 1);
    xmov(0, 0, 16'h0000, 8'h00, 1);
    chk("aux_rd", 8'h3c, q);
    chk("ext_kept", 8'ha5, mem_u.mem[16'h0034]);
    xmov(0, 1, 16'h0034, 8'h00, 1);
    chk("aux_data_pointer_pair", 8'h3c, q);
    xmov(1, 1, 16'h1234, 8'h77, 0);
    chk("ext_hi", 8'h77, mem_u.mem[16'h1234]);
    xmov(0, 1, 16'h1234, 8'h00, 0);
    chk("ext_rd", 8'h77, q);
    fetch(16'h0100, 8'h9e, 8'h9e);
    i_external_fetch_select = 0;
    repeat (3) @(negedge i_clk);
    fetch(16'h2345, 8'h00, 8'h23 ^ 8'h45 ^ 8'h5a);
    // Reset in mid-run: auxiliary RAM must be off again, pointer move goes out
    i_arst_n = 0;
    repeat (4) @(negedge i_clk);
    chk("p2_oe_n_rst", 1, o_high_addr_port_oe_n);
    i_arst_n = 1;
    sfr_r(8'hbf, 8'h00);
    xmov(0, 0, 16'h0000, 8'h00, 0);
    chk("rst_ext_rd", 8'ha5, q);
    wrap_up();
  end

  // Whole run is well under two hundred cycles; far beyond that means a hang
  initial begin
    repeat (4000) @(posedge i_clk);
    err_total++;
    wrap_up();
  end
endmodule // tb_top

bind axb_top axb_chk chk_u (.i_clk, .i_arst_n, .i_external_fetch_select, .o_ale,
  .o_program_fetch_strobe_n, .o_rd_n, .o_wr_n, .o_low_addr_data_port_oe_n,
  .o_high_addr_port_out, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .o_sfr_hit, .i_iram_req,
  .i_iram_indirect, .i_iram_addr, .o_iram_ack, .o_iram_err, .i_xmov_req, .o_xmov_ack,
  .o_xmov_on_chip);
`default_nettype wire
